// >>> core/nbu_consts.svh
`ifndef NBU_CONSTS_SVH
`define NBU_CONSTS_SVH

// register byte offsets
`define NBU_OFF_CTRL     4'h0
`define NBU_OFF_STAT     4'h4
`define NBU_OFF_DATA     4'h8
`define NBU_ADDR_W       4

// serial_control field positions
`define NBU_C_VAR        0
`define NBU_C_TSEL       1
`define NBU_C_DBL        2
`define NBU_C_T9         3
`define NBU_C_REN        4
`define NBU_C_MPF        5
`define NBU_C_IEN        6

// status field positions
`define NBU_S_TXD        0
`define NBU_S_RXD        1
`define NBU_S_R9         2
`define NBU_S_BSY        3

// timing
`define NBU_BIT_SLOW     64
`define NBU_BIT_FAST     32
`define NBU_OS_RATE      16
`define NBU_DIV_SLOW     3'(`NBU_BIT_SLOW / `NBU_OS_RATE)
`define NBU_DIV_FAST     3'(`NBU_BIT_FAST / `NBU_OS_RATE)
`define NBU_OS_LAST      4'(`NBU_OS_RATE - 1)
`define NBU_OS_MID       4'(`NBU_OS_RATE / 2 - 1)
`define NBU_LAST_DBIT    3'h7

// reset values and responses
`define NBU_CTRL_RST     7'h00
`define NBU_RESP_OKAY    2'h0
`define NBU_RESP_SLVERR  2'h2

`endif

// >>> core/nbu_pkg.sv
package nbu_pkg;

  typedef enum logic [2:0] {
    NBU_TX_IDLE  = 3'h0,
    NBU_TX_START = 3'h1,
    NBU_TX_DATA  = 3'h3,
    NBU_TX_NINTH = 3'h2,
    NBU_TX_STOP  = 3'h6
  } nbu_tx_st_t;

  typedef enum logic [2:0] {
    NBU_RX_IDLE  = 3'h0,
    NBU_RX_START = 3'h1,
    NBU_RX_DATA  = 3'h3,
    NBU_RX_NINTH = 3'h2,
    NBU_RX_STOP  = 3'h6
  } nbu_rx_st_t;

endpackage

// >>> core/nbu_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nbu_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> core/nbu_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module nbu_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic    clk_i,
  input  wire logic    sys_rst_i,
  nbu_stream_if.snk    in_s,
  nbu_stream_if.src    out_s
);
  import nbu_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wr;
    logic [AW:0]             rd;
  } nbu_fifo_st_t;

  nbu_fifo_st_t q;
  nbu_fifo_st_t d;
  logic         full;
  logic         empty;

  assign empty       = (q.wr == q.rd);
  assign full        = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = q.mem[q.rd[AW-1:0]];

  always_comb begin
    d = q;
    if (in_s.valid && !full) begin
      d.mem[q.wr[AW-1:0]] = in_s.data;
      d.wr = q.wr + 1'b1;
    end
    if (out_s.ready && !empty) begin
      d.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// >>> core/nbu_baud.sv
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.svh"
module nbu_baud (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic var_mode_i,
  input  wire logic timer_sel_i,
  input  wire logic baud_double_i,
  input  wire logic timer1_ovf_i,
  input  wire logic timer2_ovf_i,
  output logic      os_tick_o
);
  import nbu_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } nbu_baud_st_t;

  nbu_baud_st_t q;
  nbu_baud_st_t d;
  logic [2:0]   div;

  assign os_tick_o = q.tick;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    div    = baud_double_i ? `NBU_DIV_FAST : `NBU_DIV_SLOW;
    if (var_mode_i) begin
      d.cnt  = 3'h0;
      d.tick = timer_sel_i ? timer2_ovf_i : timer1_ovf_i;
    end else if (q.cnt >= div - 3'h1) begin
      d.cnt  = 3'h0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// >>> core/nbu_uart.sv
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.svh"
// Overview of operation
// - frame: start, eight data bits lsb first, ninth bit, stop
// - transmitted ninth bit is the tx_ninth_bit control value
// - received ninth bit goes to rx_ninth_bit; stop level ignored
// - writing the data buffer queues a new transmit frame in a four-deep fifo
// - tx_done_flag sets when the stop bit period begins
// - receiver accepts frames only while receive enable is set
// - accept only if rx_done_flag clear and filter passes ninth bit
// - accepted frame loads buffer, ninth bit, sets rx_done; else nothing
// - interrupt request when either flag set and interrupt enabled
// - fixed rate is clock over 64, or over 32 when doubled
// - reset clears baud_double, selecting the slower fixed rate
// - variable mode uses same frame, timed by timer one or two
// - senders mark address bytes ninth=1, data bytes ninth=0
// - no hardware address compare; software clears filter on match
module nbu_uart (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  input  wire logic        timer1_ovf_i,
  input  wire logic        timer2_ovf_i,
  output logic             serial_irq_o
);
  import nbu_pkg::*;

  typedef struct packed {
    logic                    aw_rdy;
    logic                    w_rdy;
    logic                    aw_got;
    logic                    w_got;
    logic [`NBU_ADDR_W-1:0]  aw_addr;
    logic [7:0]              w_data;
    logic                    w_strb0;
    logic                    b_valid;
    logic [1:0]              b_resp;
    logic                    ar_rdy;
    logic                    r_valid;
    logic [1:0]              r_resp;
    logic [7:0]              r_data;
    logic                    var_mode;
    logic                    timer_sel;
    logic                    baud_double;
    logic                    tx_ninth_bit;
    logic                    rx_enable;
    logic                    multiproc_filter;
    logic                    irq_enable;
    logic                    tx_done_flag;
    logic                    rx_done_flag;
    logic                    rx_ninth_bit;
    logic [7:0]              serial_data_buffer;
    logic                    irq;
    nbu_tx_st_t              tx_st;
    logic [3:0]              tx_cnt;
    logic [2:0]              tx_bit;
    logic [8:0]              tx_sh;
    logic                    txd;
    nbu_rx_st_t              rx_st;
    logic [3:0]              rx_cnt;
    logic [2:0]              rx_bit;
    logic [8:0]              rx_sh;
    logic                    rxd_prev;
  } nbu_core_st_t;

  localparam nbu_core_st_t RST_ST = '{
    aw_rdy:   1'b1,
    w_rdy:    1'b1,
    ar_rdy:   1'b1,
    txd:      1'b1,
    rxd_prev: 1'b1,
    tx_st:    NBU_TX_IDLE,
    rx_st:    NBU_RX_IDLE,
    default:  '0
  };

  nbu_core_st_t q;
  nbu_core_st_t d;
  logic         os_tick;
  logic         wr_done;
  logic [6:0]   ctrl_rd;

  nbu_stream_if #(.W(8)) tx_in ();
  nbu_stream_if #(.W(8)) tx_out ();

  nbu_fifo #(
    .W     (8),
    .DEPTH (4)
  ) u_tx_fifo (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .in_s      (tx_in),
    .out_s     (tx_out)
  );

  nbu_baud u_baud (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .var_mode_i    (q.var_mode),
    .timer_sel_i   (q.timer_sel),
    .baud_double_i (q.baud_double),
    .timer1_ovf_i  (timer1_ovf_i),
    .timer2_ovf_i  (timer2_ovf_i),
    .os_tick_o     (os_tick)
  );

  assign s_axi_awready_o = q.aw_rdy;
  assign s_axi_wready_o  = q.w_rdy;
  assign s_axi_bvalid_o  = q.b_valid;
  assign s_axi_bresp_o   = q.b_resp;
  assign s_axi_arready_o = q.ar_rdy;
  assign s_axi_rvalid_o  = q.r_valid;
  assign s_axi_rresp_o   = q.r_resp;
  assign s_axi_rdata_o   = {24'h000000, q.r_data};
  assign txd_o           = q.txd;
  assign serial_irq_o    = q.irq;

  assign tx_in.data   = q.w_data;
  assign tx_out.ready = (q.tx_st == NBU_TX_IDLE);

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[`NBU_C_VAR]  = q.var_mode;
    ctrl_rd[`NBU_C_TSEL] = q.timer_sel;
    ctrl_rd[`NBU_C_DBL]  = q.baud_double;
    ctrl_rd[`NBU_C_T9]   = q.tx_ninth_bit;
    ctrl_rd[`NBU_C_REN]  = q.rx_enable;
    ctrl_rd[`NBU_C_MPF]  = q.multiproc_filter;
    ctrl_rd[`NBU_C_IEN]  = q.irq_enable;
  end

  always_comb begin
    d           = q;
    wr_done     = 1'b0;
    tx_in.valid = 1'b0;

    // write address and data are taken independently
    if (q.aw_rdy && s_axi_awvalid_i) begin
      d.aw_rdy  = 1'b0;
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr_i[`NBU_ADDR_W-1:0];
    end
    if (q.w_rdy && s_axi_wvalid_i) begin
      d.w_rdy   = 1'b0;
      d.w_got   = 1'b1;
      d.w_data  = s_axi_wdata_i[7:0];
      d.w_strb0 = s_axi_wstrb_i[0];
    end

    if (q.aw_got && q.w_got && !q.b_valid) begin
      d.b_resp = `NBU_RESP_OKAY;
      case (q.aw_addr)
        `NBU_OFF_CTRL: begin
          wr_done = 1'b1;
          if (q.w_strb0) begin
            d.var_mode         = q.w_data[`NBU_C_VAR];
            d.timer_sel        = q.w_data[`NBU_C_TSEL];
            d.baud_double      = q.w_data[`NBU_C_DBL];
            d.tx_ninth_bit     = q.w_data[`NBU_C_T9];
            d.rx_enable        = q.w_data[`NBU_C_REN];
            d.multiproc_filter = q.w_data[`NBU_C_MPF];
            d.irq_enable       = q.w_data[`NBU_C_IEN];
          end
        end
        `NBU_OFF_STAT: begin
          wr_done = 1'b1;
          if (q.w_strb0) begin
            // writing zero clears a flag, writing one leaves it
            d.tx_done_flag = q.tx_done_flag & q.w_data[`NBU_S_TXD];
            d.rx_done_flag = q.rx_done_flag & q.w_data[`NBU_S_RXD];
          end
        end
        `NBU_OFF_DATA: begin
          if (!q.w_strb0) begin
            wr_done = 1'b1;
          end else if (tx_in.ready) begin
            // a full fifo holds the write response back
            tx_in.valid = 1'b1;
            wr_done     = 1'b1;
          end
        end
        default: begin
          wr_done  = 1'b1;
          d.b_resp = `NBU_RESP_SLVERR;
        end
      endcase
      if (wr_done) begin
        d.b_valid = 1'b1;
      end
    end
    if (q.b_valid && s_axi_bready_i) begin
      d.b_valid = 1'b0;
      d.aw_got  = 1'b0;
      d.w_got   = 1'b0;
      d.aw_rdy  = 1'b1;
      d.w_rdy   = 1'b1;
    end

    // reads have no side effect
    if (q.ar_rdy && s_axi_arvalid_i) begin
      d.ar_rdy  = 1'b0;
      d.r_valid = 1'b1;
      d.r_resp  = `NBU_RESP_OKAY;
      d.r_data  = 8'h00;
      case (s_axi_araddr_i[`NBU_ADDR_W-1:0])
        `NBU_OFF_CTRL: begin
          d.r_data = {1'b0, ctrl_rd};
        end
        `NBU_OFF_STAT: begin
          d.r_data[`NBU_S_TXD] = q.tx_done_flag;
          d.r_data[`NBU_S_RXD] = q.rx_done_flag;
          d.r_data[`NBU_S_R9]  = q.rx_ninth_bit;
          d.r_data[`NBU_S_BSY] = (q.tx_st != NBU_TX_IDLE);
        end
        `NBU_OFF_DATA: begin
          d.r_data = q.serial_data_buffer;
        end
        default: begin
          d.r_resp = `NBU_RESP_SLVERR;
        end
      endcase
    end
    if (q.r_valid && s_axi_rready_i) begin
      d.r_valid = 1'b0;
      d.ar_rdy  = 1'b1;
    end

    // transmitter, sixteen oversample ticks per bit
    case (q.tx_st)
      NBU_TX_IDLE: begin
        d.txd = 1'b1;
        if (tx_out.valid) begin
          d.tx_sh  = {q.tx_ninth_bit, tx_out.data};
          d.tx_st  = NBU_TX_START;
          d.tx_cnt = 4'h0;
          d.txd    = 1'b0;
        end
      end
      NBU_TX_START, NBU_TX_DATA, NBU_TX_NINTH, NBU_TX_STOP: begin
        if (os_tick) begin
          d.tx_cnt = q.tx_cnt + 4'h1;
          if (q.tx_cnt == `NBU_OS_LAST) begin
            d.tx_cnt = 4'h0;
            case (q.tx_st)
              NBU_TX_START: begin
                d.tx_st  = NBU_TX_DATA;
                d.tx_bit = 3'h0;
                d.txd    = q.tx_sh[0];
              end
              NBU_TX_DATA: begin
                d.tx_sh  = {1'b0, q.tx_sh[8:1]};
                d.txd    = q.tx_sh[1];
                d.tx_bit = q.tx_bit + 3'h1;
                if (q.tx_bit == `NBU_LAST_DBIT) begin
                  d.tx_st = NBU_TX_NINTH;
                end
              end
              NBU_TX_NINTH: begin
                d.tx_st        = NBU_TX_STOP;
                d.txd          = 1'b1;
                d.tx_done_flag = 1'b1;
              end
              default: begin
                d.tx_st = NBU_TX_IDLE;
              end
            endcase
          end
        end
      end
      default: begin
        d.tx_st = NBU_TX_IDLE;
      end
    endcase

    // receiver
    d.rxd_prev = rxd_i;
    case (q.rx_st)
      NBU_RX_IDLE: begin
        if (q.rx_enable && q.rxd_prev && !rxd_i) begin
          d.rx_st  = NBU_RX_START;
          d.rx_cnt = 4'h0;
        end
      end
      NBU_RX_START, NBU_RX_DATA, NBU_RX_NINTH, NBU_RX_STOP: begin
        if (!q.rx_enable) begin
          d.rx_st = NBU_RX_IDLE;
        end else if (os_tick) begin
          d.rx_cnt = q.rx_cnt + 4'h1;
          if (q.rx_st == NBU_RX_START) begin
            if (q.rx_cnt == `NBU_OS_MID) begin
              d.rx_cnt = 4'h0;
              d.rx_bit = 3'h0;
              // a glitch that is high again at mid start is dropped
              d.rx_st  = rxd_i ? NBU_RX_IDLE : NBU_RX_DATA;
            end
          end else if (q.rx_cnt == `NBU_OS_LAST) begin
            d.rx_cnt = 4'h0;
            case (q.rx_st)
              NBU_RX_DATA: begin
                d.rx_sh  = {rxd_i, q.rx_sh[8:1]};
                d.rx_bit = q.rx_bit + 3'h1;
                if (q.rx_bit == `NBU_LAST_DBIT) begin
                  d.rx_st = NBU_RX_NINTH;
                end
              end
              NBU_RX_NINTH: begin
                d.rx_sh = {rxd_i, q.rx_sh[8:1]};
                d.rx_st = NBU_RX_STOP;
              end
              default: begin
                // stop level is not checked
                d.rx_st = NBU_RX_IDLE;
                if (!q.rx_done_flag &&
                    (!q.multiproc_filter || q.rx_sh[8])) begin
                  d.serial_data_buffer = q.rx_sh[7:0];
                  d.rx_ninth_bit       = q.rx_sh[8];
                  d.rx_done_flag       = 1'b1;
                end
              end
            endcase
          end
        end
      end
      default: begin
        d.rx_st = NBU_RX_IDLE;
      end
    endcase

    d.irq = q.irq_enable && (q.tx_done_flag || q.rx_done_flag);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= RST_ST;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// >>> verification/nbu_uart_props.sv
`timescale 1ns/1ps
`default_nettype none
module nbu_uart_props (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        txd_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // longest legal low run: start plus nine zero bits, slowest bit, phase slack
  logic [9:0] low_q;
  logic [9:0] low_d;

  always_comb low_d = txd_o ? 10'h0 : low_q + 10'h1;
  always_ff @(posedge clk_i) low_q <= sys_rst_i ? 10'h0 : low_d;

  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  property p_wr_resp;
    s_wr_take |=> !s_axi_bvalid_o ##[1:899] s_axi_bvalid_o;
  endproperty
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  property p_b_block;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  property p_rd_lat;
    s_rd_take |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  property p_rd_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o) && s_axi_rvalid_o;
  endproperty
  property p_rd_zero;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0;
  endproperty
  property p_unmap;
    s_rd_take ##0 !(s_axi_araddr_i[3:0] inside {4'h0, 4'h4, 4'h8})
      |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0;
  endproperty
  property p_tx_low;
    low_q <= 10'h284;
  endproperty

  a_wr_resp: assert property (p_wr_resp)
    else $error("write response out of window");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_b_block: assert property (p_b_block)
    else $error("write taken during response");
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data not one cycle after address");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed before taken");
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data upper bits set");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not refused");
  a_tx_low: assert property (p_tx_low)
    else $error("serial output low past a frame");
endmodule

bind nbu_uart nbu_uart_props u_props (
  .clk_i, .sys_rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .txd_o
);
`default_nettype wire

// >>> verification/nbu_remote.sv
`timescale 1ns/1ps
`default_nettype none
module nbu_remote (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  int         bit_clks = 64;
  logic [8:0] got_q[$];
  logic [8:0] v;
  logic       line_q = 1'b1;

  // one driver for the line; the send task only moves line_q
  assign line_o = line_q;

  task automatic send(input logic [7:0] d, input logic n, input logic s);
    logic [10:0] f;
    f = {s, n, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_q <= f[i];
      repeat (bit_clks) @(posedge clk_i);
    end
    line_q <= 1'b1;
  endtask

  // samples mid-bit; waits to mid stop so data edges are not taken as start
  always begin
    @(negedge line_i);
    repeat (bit_clks / 2) @(posedge clk_i);
    if (!line_i) begin
      for (int i = 0; i < 10; i++) begin
        repeat (bit_clks) @(posedge clk_i);
        if (i < 9) v[i] = line_i;
      end
      got_q.push_back(v);
    end
  end
endmodule
`default_nettype wire

// >>> verification/nbu_uart_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nbu_uart_tb;
  logic        clk_i, sys_rst_i, rxd_i, txd_o, timer1_ovf_i, timer2_ovf_i;
  logic        serial_irq_o, s_axi_awvalid_i, s_axi_awready_o;
  logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic        s_axi_rvalid_o, s_axi_rready_i;
  logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, tcnt = 2'h0;
  logic [7:0]  d, e_buf;
  logic        n, ien, e_txd, e_rxd, e_r9;
  logic [7:0]  exq[$];
  int          bad_count, tests_run, cyc;
  int          bc[4] = '{64, 32, 32, 64};
  logic [2:0]  mc[4] = '{3'b000, 3'b100, 3'b001, 3'b011};
  logic [4:0]  ren = 5'b01111;
  logic [4:0]  mpf = 5'b01100;
  logic [4:0]  clr = 5'b10100;
  logic [4:0]  nin = 5'b11000;
  logic [4:0]  iev = 5'b11101;

  nbu_uart DUT (
    .clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .rxd_i, .txd_o, .timer1_ovf_i,
    .timer2_ovf_i, .serial_irq_o
  );
  nbu_remote RMT (.clk_i, .line_i(txd_o), .line_o(rxd_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // timer one overflows every 2 clocks, timer two every 4
  always @(posedge clk_i) begin
    tcnt <= tcnt + 2'h1;
    timer1_ovf_i <= tcnt[0];
    timer2_ovf_i <= (tcnt == 2'h3);
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] dv,
                     input logic [3:0] s, input logic [1:0] er);
    logic aw;
    logic w;
    {aw, w} = 2'b11;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= dv;
    s_axi_wstrb_i <= s;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
    while (aw || w) begin
      @(posedge clk_i);
      if (s_axi_awready_o) aw = 1'b0;
      if (s_axi_wready_o) w = 1'b0;
      s_axi_awvalid_i <= aw;
      s_axi_wvalid_i <= w;
    end
    do @(posedge clk_i); while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
    chk({30'h0, s_axi_bresp_o}, {30'h0, er});
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    chk(s_axi_rdata_o, e);
    chk({30'h0, s_axi_rresp_o}, {30'h0, er});
    @(posedge clk_i);
  endtask

  task automatic ck_stat();
    rd(32'h4, {28'h0, 1'b0, e_r9, e_rxd, e_txd}, 2'h0);
    chk({31'h0, serial_irq_o}, {31'h0, ien & (e_txd | e_rxd)});
  endtask

  task automatic tx_done_clear(input int b);
    repeat (b) @(posedge clk_i);
    e_txd = 1'b1;
    ck_stat();
    axw(32'h4, 32'h0, 4'hf, 2'h0);
    e_txd = 1'b0;
    ck_stat();
  endtask

  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'b000;
    {s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = 96'h0;
    {s_axi_wstrb_i, e_buf} = 12'h0;
    {ien, e_txd, e_rxd, e_r9, sys_rst_i} = 5'b10001;
    void'($urandom(32'h93e8));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(32'h0, 32'h0, 2'h0);
    rd(32'h4, 32'h0, 2'h0);
    rd(32'hc, 32'h0, 2'h2);
    axw(32'hc, 32'h0, 4'hf, 2'h2);
    axw(32'h0, 32'h7f, 4'h0, 2'h0);
    rd(32'h0, 32'h0, 2'h0);
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        d = 8'($urandom);
        // both ninth-bit values in every rate
        n = k[0];
        RMT.bit_clks = bc[m];
        axw(32'h0, {25'h0, ien, 2'b00, n, mc[m]}, 4'hf, 2'h0);
        axw(32'h8, {24'h0, d}, 4'hf, 2'h0);
        while (RMT.got_q.size() == 0) @(posedge clk_i);
        chk({23'h0, RMT.got_q.pop_front()}, {23'h0, n, d});
        // mid stop bit: done flag already set, shifter still busy
        rd(32'h4, 32'h9, 2'h0);
        tx_done_clear(bc[m]);
      end
    end
    // six writes overrun the four-deep queue plus shifter, stalling one
    RMT.bit_clks = 32;
    axw(32'h0, {25'h0, ien, 6'b000100}, 4'hf, 2'h0);
    for (int k = 0; k < 6; k++) begin
      d = 8'($urandom);
      exq.push_back(d);
      axw(32'h8, {24'h0, d}, 4'hf, 2'h0);
    end
    // stalled write returns once the first frame is out
    rd(32'h4, 32'h9, 2'h0);
    for (int k = 0; k < 6; k++) begin
      while (RMT.got_q.size() == 0) @(posedge clk_i);
      chk({23'h0, RMT.got_q.pop_front()}, {24'h0, exq.pop_front()});
    end
    tx_done_clear(32);
    RMT.bit_clks = 64;
    for (int i = 0; i < 5; i++) begin
      if (clr[i]) begin
        axw(32'h4, 32'h0, 4'hf, 2'h0);
        e_rxd = 1'b0;
      end
      ien = iev[i];
      axw(32'h0, {25'h0, ien, mpf[i], ren[i], 4'h0}, 4'hf, 2'h0);
      d = 8'($urandom);
      RMT.send(d, nin[i], i[0]);
      repeat (4) @(posedge clk_i);
      if (ren[i] && !e_rxd && (!mpf[i] || nin[i])) begin
        {e_rxd, e_r9, e_buf} = {1'b1, nin[i], d};
      end
      ck_stat();
      rd(32'h8, {24'h0, e_buf}, 2'h0);
    end
    final_report();
  end
endmodule
`default_nettype wire
